// file: hw/radio_timing_wake_config.sv
// timing, amplifier level and wake-up controller configuration registers
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_timing_wake_params.svh"

// How it works
// [RULE1] transition code 1 gives fast transitions, codes 0 and 4 normal timing
// [RULE2] custom mode: receive lock waits rx count times 2 us after VCO calibration
// [RULE3] custom mode: transmit lock waits tx count times 2 us after VCO calibration
// [RULE4] entering sleep wipes every volatile register image; software reprograms after wake
// [RULE5] six-bit amplifier target, reset 0; ramping steps the drive toward it
// [RULE6] host writes high wake config before low; low write applies both
// [RULE7] low config bit 4 picks RC oscillator when 1, crystal when 0
// [RULE8] low config bit 3 keeps retention RAM powered during sleep
// [RULE9] low config bit 0 lets a timer timeout wake the device
// [RULE10] reload high byte is held pending until the low byte is written
// [RULE11] timer counts down reload value per tick, event at zero while enabled
// [RULE12] prescaler divides the 32.768 kHz clock by 1,4,8,16,128,1024,8192,65536
module radio_timing_wake_config
    import radio_timing_wake_pkg::*;
#(
    parameter int LOCK_UNIT_CYCLES = `LOCK_UNIT_NS / `CLK_PERIOD_NS,
    parameter int RAMP_STEP_CYCLES = `RAMP_STEP_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_state,
    input wire logic rx_vco_cal_done,
    input wire logic tx_vco_cal_done,
    input wire logic rc_osc_clk_in,
    input wire logic xtal_osc_clk_in,
    output logic fast_transition,
    output logic rx_synth_locked,
    output logic tx_synth_locked,
    output logic [5:0] amp_drive_level,
    output logic [3:0] rc_osc_coarse_trim,
    output logic rc_osc_enable,
    output logic crystal_osc_enable,
    output logic retention_ram_power_en,
    output logic wake_request,
    output logic irq
);

    // register images and applied state
    byte_t trans_speed_ff, rx_wait_ff, tx_wait_ff, mode_ff, cfg_high_ff, cfg_low_ff, reload_hi_ff;
    byte_t rdata_ff;
    logic [5:0] amp_level_ff, amp_drive_ff;
    logic [`IRQ_W-1:0] irq_stat_ff, irq_en_ff;
    logic fast_ff, irq_ff, sleep_prev_ff;
    logic [3:0] trim_ff;
    logic rc_en_ff, xtal_en_ff, clk_sel_ff, ram_keep_ff, arm_ff, ram_pwr_ff;
    logic [2:0] div_sel_ff;
    logic [15:0] reload_ff, timer_ff;
    logic [16:0] presc_ff;
    logic timeout_ff, wake_ff;
    lock_state_t lock_state_ff;
    logic lock_is_tx_ff, rx_lock_ff, tx_lock_ff;
    logic [15:0] unit_cnt_ff;
    logic [7:0] units_left_ff;
    logic [1:0] osc_s1_ff, osc_s2_ff, osc_prev_ff;

    // address decode
    wire logic wr_trans = reg_wr && (reg_addr == `OFF_TRANSITION_SPEED);
    wire logic wr_rx_wait = reg_wr && (reg_addr == `OFF_RX_LOCK_WAIT);
    wire logic wr_tx_wait = reg_wr && (reg_addr == `OFF_TX_LOCK_WAIT);
    wire logic wr_amp = reg_wr && (reg_addr == `OFF_AMP_TARGET);
    wire logic wr_cfg_high = reg_wr && (reg_addr == `OFF_WAKE_CFG_HIGH);
    wire logic wr_cfg_low = reg_wr && (reg_addr == `OFF_WAKE_CFG_LOW);
    wire logic wr_rel_high = reg_wr && (reg_addr == `OFF_WAKE_RELOAD_HIGH);
    wire logic wr_rel_low = reg_wr && (reg_addr == `OFF_WAKE_RELOAD_LOW);
    wire logic wr_mode = reg_wr && (reg_addr == `OFF_MODE_CONTROL);
    wire logic wr_irq_clr = reg_wr && (reg_addr == `OFF_IRQ_CLEAR);
    wire logic wr_irq_en = reg_wr && (reg_addr == `OFF_IRQ_ENABLE);
    wire logic sleep_entry = sleep_state && !sleep_prev_ff;
    wire logic custom_lock_wait_en = mode_ff[`BIT_MODE_CUSTOM_LOCK];
    wire logic ramp_en = mode_ff[`BIT_MODE_RAMP];

    // read mux: write-only registers and unmapped addresses read as zero
    wire byte_t rd_mux =
        (reg_addr == `OFF_TRANSITION_SPEED) ? trans_speed_ff :
        (reg_addr == `OFF_RX_LOCK_WAIT) ? rx_wait_ff :
        (reg_addr == `OFF_TX_LOCK_WAIT) ? tx_wait_ff :
        (reg_addr == `OFF_AMP_TARGET) ? {2'h0, amp_level_ff} :
        (reg_addr == `OFF_MODE_CONTROL) ? mode_ff :
        (reg_addr == `OFF_IRQ_STATUS) ? {5'h00, irq_stat_ff} :
        (reg_addr == `OFF_IRQ_ENABLE) ? {5'h00, irq_en_ff} : `RST_BYTE;

    // host read port, data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_ff <= `RST_BYTE;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : `RST_BYTE;
        end
    end

    // timing, mode and interrupt enable registers outside the volatile space
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            trans_speed_ff <= `RST_BYTE;
            rx_wait_ff <= `RST_BYTE;
            tx_wait_ff <= `RST_BYTE;
            mode_ff <= `RST_BYTE;
            irq_en_ff <= '0;
        end else begin
            if (wr_trans) trans_speed_ff <= reg_wdata;
            if (wr_rx_wait) rx_wait_ff <= reg_wdata;
            if (wr_tx_wait) tx_wait_ff <= reg_wdata;
            if (wr_mode) mode_ff <= reg_wdata;
            if (wr_irq_en) irq_en_ff <= reg_wdata[`IRQ_W-1:0];
        end
    end

    // [RULE1] transition code decode
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fast_ff <= 1'b0;
        end else begin
            fast_ff <= (trans_speed_ff[2:0] == `CODE_FAST);
        end
    end

    // [RULE4] [RULE5] [RULE10] volatile images, wiped on sleep entry
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sleep_prev_ff <= 1'b0;
            amp_level_ff <= `RST_AMP;
            cfg_high_ff <= `RST_BYTE;
            cfg_low_ff <= `RST_BYTE;
            reload_hi_ff <= `RST_BYTE;
        end else begin
            sleep_prev_ff <= sleep_state;
            if (sleep_entry) begin
                amp_level_ff <= `RST_AMP;
                cfg_high_ff <= `RST_BYTE;
                cfg_low_ff <= `RST_BYTE;
                reload_hi_ff <= `RST_BYTE;
            end else begin
                if (wr_amp) amp_level_ff <= reg_wdata[5:0];
                if (wr_cfg_high) cfg_high_ff <= reg_wdata;
                if (wr_cfg_low) cfg_low_ff <= reg_wdata;
                if (wr_rel_high) reload_hi_ff <= reg_wdata;
            end
        end
    end

    // [RULE5] amplifier drive ramps one step per interval, or follows directly
    logic [15:0] ramp_cnt_ff;
    wire logic ramp_step = (ramp_cnt_ff == 16'(RAMP_STEP_CYCLES - 1));
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ramp_cnt_ff <= '0;
            amp_drive_ff <= `RST_AMP;
        end else begin
            ramp_cnt_ff <= ramp_step ? '0 : ramp_cnt_ff + 16'h0001;
            if (!ramp_en) begin
                amp_drive_ff <= amp_level_ff;
            end else if (ramp_step && amp_drive_ff < amp_level_ff) begin
                amp_drive_ff <= amp_drive_ff + 6'h01;
            end else if (ramp_step && amp_drive_ff > amp_level_ff) begin
                amp_drive_ff <= amp_drive_ff - 6'h01;
            end
        end
    end

    // [RULE6] low write applies the high image written just before it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            trim_ff <= 4'h0;
            div_sel_ff <= 3'h0;
            rc_en_ff <= 1'b0;
            xtal_en_ff <= 1'b0;
            clk_sel_ff <= 1'b0;
            ram_keep_ff <= 1'b0;
            arm_ff <= 1'b0;
        end else if (wr_cfg_low) begin
            trim_ff <= cfg_high_ff[6:3];
            div_sel_ff <= cfg_high_ff[2:0];
            rc_en_ff <= reg_wdata[`BIT_CFG_RC_EN];
            xtal_en_ff <= reg_wdata[`BIT_CFG_XTAL_EN];
            // [RULE7] timer clock source
            clk_sel_ff <= reg_wdata[`BIT_CFG_CLK_SEL];
            ram_keep_ff <= reg_wdata[`BIT_CFG_RAM_KEEP];
            arm_ff <= reg_wdata[`BIT_CFG_ARM];
        end
    end

    // [RULE8] retention RAM power gated only while asleep
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ram_pwr_ff <= 1'b1;
        end else begin
            ram_pwr_ff <= !sleep_state || ram_keep_ff;
        end
    end

    // two-stage synchronisers for both 32.768 kHz oscillator inputs
    wire logic [1:0] osc_pins = {xtal_osc_clk_in, rc_osc_clk_in};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_osc_sync
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    osc_s1_ff[gi] <= 1'b0;
                    osc_s2_ff[gi] <= 1'b0;
                    osc_prev_ff[gi] <= 1'b0;
                end else begin
                    osc_s1_ff[gi] <= osc_pins[gi];
                    osc_s2_ff[gi] <= osc_s1_ff[gi];
                    osc_prev_ff[gi] <= osc_s2_ff[gi];
                end
            end
        end
    endgenerate

    // [RULE12] divider terminal value per prescaler code
    function automatic logic [16:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h0: div_last = 17'h00000;
            3'h1: div_last = 17'h00003;
            3'h2: div_last = 17'h00007;
            3'h3: div_last = 17'h0000F;
            3'h4: div_last = 17'h0007F;
            3'h5: div_last = 17'h003FF;
            3'h6: div_last = 17'h01FFF;
            default: div_last = 17'h0FFFF;
        endcase
    endfunction : div_last

    // selected source edge and tick; unit runs while its oscillator is on
    wire logic [1:0] osc_rise = osc_s2_ff & ~osc_prev_ff;
    wire logic src_edge = clk_sel_ff ? osc_rise[0] : osc_rise[1];
    wire logic wake_unit_en = clk_sel_ff ? rc_en_ff : xtal_en_ff;
    wire logic presc_end = (presc_ff == div_last(div_sel_ff));
    wire logic tick = wake_unit_en && src_edge && presc_end;

    // [RULE12] prescaler counts source edges
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            presc_ff <= '0;
        end else if (wr_rel_low || !wake_unit_en) begin
            presc_ff <= '0;
        end else if (src_edge) begin
            presc_ff <= presc_end ? '0 : presc_ff + 17'h00001;
        end
    end

    // [RULE10] [RULE11] reload load, countdown and timeout event
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reload_ff <= '0;
            timer_ff <= '0;
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= tick && (timer_ff == 16'h0000);
            if (wr_rel_low) begin
                reload_ff <= {reload_hi_ff, reg_wdata};
                timer_ff <= {reload_hi_ff, reg_wdata};
            end else if (tick) begin
                timer_ff <= (timer_ff == 16'h0000) ? reload_ff : timer_ff - 16'h0001;
            end
        end
    end

    // [RULE9] timeout wakes the device only when armed
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= timeout_ff && arm_ff;
        end
    end

    // [RULE2] [RULE3] synthesizer lock wait after VCO calibration
    wire logic cal_req = rx_vco_cal_done || tx_vco_cal_done;
    wire byte_t req_count = tx_vco_cal_done ? tx_wait_ff : rx_wait_ff;
    wire logic unit_end = (unit_cnt_ff == 16'(LOCK_UNIT_CYCLES - 1));
    wire logic skip_wait = !custom_lock_wait_en || (req_count == 8'h00);
    wire logic wait_end = (lock_state_ff == LOCK_WAIT) && unit_end && (units_left_ff == 8'h01);
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            lock_state_ff <= LOCK_IDLE;
            lock_is_tx_ff <= 1'b0;
            unit_cnt_ff <= '0;
            units_left_ff <= '0;
            rx_lock_ff <= 1'b0;
            tx_lock_ff <= 1'b0;
        end else begin
            rx_lock_ff <= 1'b0;
            tx_lock_ff <= 1'b0;
            case (lock_state_ff)
                LOCK_IDLE: begin
                    unit_cnt_ff <= '0;
                    if (cal_req && skip_wait) begin
                        rx_lock_ff <= !tx_vco_cal_done;
                        tx_lock_ff <= tx_vco_cal_done;
                    end else if (cal_req) begin
                        lock_state_ff <= LOCK_WAIT;
                        lock_is_tx_ff <= tx_vco_cal_done;
                        units_left_ff <= req_count;
                    end
                end
                LOCK_WAIT: begin
                    unit_cnt_ff <= unit_end ? '0 : unit_cnt_ff + 16'h0001;
                    if (unit_end) units_left_ff <= units_left_ff - 8'h01;
                    if (wait_end) begin
                        lock_state_ff <= LOCK_IDLE;
                        rx_lock_ff <= !lock_is_tx_ff;
                        tx_lock_ff <= lock_is_tx_ff;
                    end
                end
                default: lock_state_ff <= LOCK_IDLE;
            endcase
        end
    end

    // sticky event flags; a set in the clearing cycle wins
    wire logic [`IRQ_W-1:0] irq_set = {tx_lock_ff, rx_lock_ff, timeout_ff};
    wire logic [`IRQ_W-1:0] irq_clr = wr_irq_clr ? reg_wdata[`IRQ_W-1:0] : '0;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_stat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_ff;
    assign fast_transition = fast_ff;
    assign rx_synth_locked = rx_lock_ff;
    assign tx_synth_locked = tx_lock_ff;
    assign amp_drive_level = amp_drive_ff;
    assign rc_osc_coarse_trim = trim_ff;
    assign rc_osc_enable = rc_en_ff;
    assign crystal_osc_enable = xtal_en_ff;
    assign retention_ram_power_en = ram_pwr_ff;
    assign wake_request = wake_ff;
    assign irq = irq_ff;

    // helper: cycles spent since the lock wait started
    logic [23:0] wait_cycles_ff;
    logic [23:0] wait_target_ff;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wait_cycles_ff <= '0;
            wait_target_ff <= '0;
        end else if (lock_state_ff == LOCK_IDLE) begin
            wait_cycles_ff <= 24'h000001;
            wait_target_ff <= 24'(req_count) * 24'(LOCK_UNIT_CYCLES);
        end else begin
            wait_cycles_ff <= wait_cycles_ff + 24'h000001;
        end
    end

    // checks on the logic above
    // [RULE1] fast code reaches the output
    AST_FAST_CODE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
        wr_trans && reg_wdata[2:0] == `CODE_FAST |=> ##1 fast_ff)
        else $error("fast transition not decoded");
    // [RULE2] receive wait length
    AST_RX_WAIT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
        rx_lock_ff && custom_lock_wait_en && $past(lock_state_ff == LOCK_WAIT)
        |-> wait_cycles_ff == wait_target_ff + 24'h000001)
        else $error("receive lock wait has wrong length");
    // [RULE3] transmit wait length
    AST_TX_WAIT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
        tx_lock_ff && $past(lock_state_ff == LOCK_WAIT)
        |-> wait_cycles_ff == wait_target_ff + 24'h000001)
        else $error("transmit lock wait has wrong length");
    // [RULE4] sleep entry wipes amplifier target
    AST_SLEEP_WIPE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE4]
        sleep_entry |=> amp_level_ff == `RST_AMP && cfg_high_ff == `RST_BYTE)
        else $error("volatile settings survived sleep entry");
    // [RULE5] amplifier target stored
    AST_AMP_STORE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
        wr_amp && !sleep_entry |=> amp_level_ff == $past(reg_wdata[5:0]))
        else $error("amplifier target not stored");
    // [RULE7] clock source applied on low write
    AST_CLK_SRC: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
        wr_cfg_low |=> clk_sel_ff == $past(reg_wdata[`BIT_CFG_CLK_SEL]))
        else $error("timer clock source not applied");
    // [RULE8] retention RAM unpowered in sleep without keep
    AST_RAM_OFF: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE8]
        (sleep_state && !ram_keep_ff) [*2] |-> !ram_pwr_ff)
        else $error("retention RAM powered in sleep");
    // [RULE9] wake only from an armed timeout
    AST_ARM_GATE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE9]
        wake_ff |-> $past(timeout_ff) && $past(arm_ff))
        else $error("wake without armed timeout");
    // [RULE10] high byte alone leaves reload untouched
    AST_RELOAD_HOLD: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE10]
        wr_rel_high |=> $stable(reload_ff))
        else $error("reload changed before low byte");
    // [RULE11] zero count on tick gives timeout and reload
    AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE11]
        tick && timer_ff == 16'h0000 && !wr_rel_low |=> timeout_ff && timer_ff == reload_ff)
        else $error("timer zero without timeout");
    // [RULE12] ticks only at divider end
    AST_PRESCALE: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE12]
        tick |-> presc_ff == div_last(div_sel_ff) && src_edge)
        else $error("tick off divider boundary");

    COV_CUSTOM_RX: cover property (@(posedge core_clk) disable iff (!nrst)
        rx_lock_ff && custom_lock_wait_en);
    COV_WAKE: cover property (@(posedge core_clk) disable iff (!nrst) wake_ff);
    COV_SLEEP: cover property (@(posedge core_clk) disable iff (!nrst) sleep_entry);
    COV_IRQ: cover property (@(posedge core_clk) disable iff (!nrst) irq_ff);

endmodule : radio_timing_wake_config
`default_nettype wire

// file: hw/radio_timing_wake_params.svh
// offsets, field positions, reset values and timing counts of the timing and wake-up registers
`ifndef RADIO_TIMING_WAKE_PARAMS_SVH
`define RADIO_TIMING_WAKE_PARAMS_SVH

`define ADDR_W 10
`define OFF_TRANSITION_SPEED 10'h13A
`define OFF_RX_LOCK_WAIT 10'h13E
`define OFF_TX_LOCK_WAIT 10'h13F
`define OFF_AMP_TARGET 10'h307
`define OFF_WAKE_CFG_HIGH 10'h30C
`define OFF_WAKE_CFG_LOW 10'h30D
`define OFF_WAKE_RELOAD_HIGH 10'h30E
`define OFF_WAKE_RELOAD_LOW 10'h30F
`define OFF_MODE_CONTROL 10'h3F0
`define OFF_IRQ_STATUS 10'h3F1
`define OFF_IRQ_CLEAR 10'h3F2
`define OFF_IRQ_ENABLE 10'h3F3

`define RST_BYTE 8'h00
`define RST_AMP 6'h00
`define CODE_FAST 3'h1

`define BIT_MODE_CUSTOM_LOCK 0
`define BIT_MODE_RAMP 1
`define BIT_CFG_RC_EN 6
`define BIT_CFG_XTAL_EN 5
`define BIT_CFG_CLK_SEL 4
`define BIT_CFG_RAM_KEEP 3
`define BIT_CFG_ARM 0
`define IRQ_WAKE 0
`define IRQ_RX_LOCK 1
`define IRQ_TX_LOCK 2
`define IRQ_W 3

`define CLK_PERIOD_NS 10
`define LOCK_UNIT_NS 2000
`define RAMP_STEP_CYCLES_DEF 16

`endif

// file: hw/radio_timing_wake_pkg.sv
// types shared by the timing and wake-up configuration block
package radio_timing_wake_pkg;
    typedef enum logic [1:0] {LOCK_IDLE, LOCK_WAIT} lock_state_t;
    typedef logic [7:0] byte_t;
endpackage : radio_timing_wake_pkg

// file: verif/radio_timing_wake_config_test.sv
// self-checking bench for the timing, amplifier and wake-up configuration block
`timescale 1ns/1ps
`default_nettype none
`include "radio_timing_wake_params.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module radio_timing_wake_config_test;
    localparam int UNIT = 2;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [`ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_state = 1'b0;
    logic rx_vco_cal_done = 1'b0;
    logic tx_vco_cal_done = 1'b0;
    logic [2:0] osc_cnt = 3'h0;
    logic [7:0] reg_rdata;
    logic fast_transition, rx_synth_locked, tx_synth_locked;
    logic [5:0] amp_drive_level;
    logic [3:0] rc_osc_coarse_trim;
    logic [3:0] trim;
    logic rc_osc_enable, crystal_osc_enable, retention_ram_power_en, wake_request, irq;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int mdl[int];
    int t, n;
    int rd_list[7] = '{'h307, 'h30C, 'h30D, 'h30E, 'h30F, 'h3F1, 'h055};
    radio_timing_wake_config #(.LOCK_UNIT_CYCLES(UNIT), .RAMP_STEP_CYCLES(2)) uut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_state(sleep_state),
        .rx_vco_cal_done(rx_vco_cal_done), .tx_vco_cal_done(tx_vco_cal_done),
        .rc_osc_clk_in(osc_cnt[1]), .xtal_osc_clk_in(osc_cnt[2]),
        .fast_transition(fast_transition), .rx_synth_locked(rx_synth_locked),
        .tx_synth_locked(tx_synth_locked), .amp_drive_level(amp_drive_level),
        .rc_osc_coarse_trim(rc_osc_coarse_trim), .rc_osc_enable(rc_osc_enable),
        .crystal_osc_enable(crystal_osc_enable), .retention_ram_power_en(retention_ram_power_en),
        .wake_request(wake_request), .irq(irq));
    // core clock, 10 ns
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // slow oscillators: rc period 4 cycles, crystal period 8 cycles
    always @(posedge core_clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            test_done();
        end
    end
    // read-write mask of each register, zero for write-only and unmapped places
    function automatic int rw_mask(input int a);
        case (a)
            `OFF_TRANSITION_SPEED, `OFF_RX_LOCK_WAIT, `OFF_TX_LOCK_WAIT: return 'hFF;
            `OFF_AMP_TARGET: return 'h3F;
            `OFF_MODE_CONTROL: return 'h3;
            `OFF_IRQ_ENABLE: return 'h7;
            default: return 0;
        endcase
    endfunction : rw_mask
    function automatic int mdl_val(input int a);
        return mdl.exists(a) ? mdl[a] : 0;
    endfunction : mdl_val
    function automatic int div(input int code);
        case (code)
            0: return 1;
            1: return 4;
            2: return 8;
            3: return 16;
            default: return 128;
        endcase
    endfunction : div
    task automatic wr(input int a, input int d);
        @(posedge core_clk);
        reg_addr <= a[9:0];
        reg_wdata <= d[7:0];
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (rw_mask(a) != 0) mdl[a] = d & rw_mask(a);
    endtask : wr
    task automatic rd_chk(input int a, input int e);
        @(posedge core_clk);
        reg_addr <= a[9:0];
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e[7:0])
    endtask : rd_chk
    // counts edges until the chosen pulse shows, bounded by lim
    task automatic wait_sig(input int which, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            // calibration strobes last one cycle, counted from the edge that takes them
            rx_vco_cal_done <= 1'b0;
            tx_vco_cal_done <= 1'b0;
            #1;
            cnt++;
        end while (!(which == 0 ? rx_synth_locked === 1'b1 : which == 1 ?
            tx_synth_locked === 1'b1 : wake_request === 1'b1) && cnt < lim);
    endtask : wait_sig
    task automatic lock_chk(input int tx, input int cnt, input int en);
        wr(`OFF_MODE_CONTROL, en);
        wr(tx ? `OFF_TX_LOCK_WAIT : `OFF_RX_LOCK_WAIT, cnt);
        @(posedge core_clk);
        if (tx) tx_vco_cal_done <= 1'b1;
        else rx_vco_cal_done <= 1'b1;
        wait_sig(tx, 2000, n);
        `CHK(n, (en != 0 && cnt != 0) ? cnt * UNIT + 1 : 1)
    endtask : lock_chk
    task automatic wake_chk(input int sel, input int code, input int rel);
        trim = 4'($urandom);
        wr(`OFF_WAKE_CFG_HIGH, code | (int'(trim) << 3));
        wr(`OFF_WAKE_CFG_LOW, 'h69 | (sel << 4));
        wr(`OFF_WAKE_RELOAD_HIGH, 0);
        wr(`OFF_WAKE_RELOAD_LOW, rel);
        wait_sig(2, 5000, n);
        wait_sig(2, 5000, n);
        `CHK(n, div(code) * (rel + 1) * (sel != 0 ? 4 : 8))
        `CHK({rc_osc_coarse_trim, rc_osc_enable, crystal_osc_enable}, {trim, 2'b11})
    endtask : wake_chk
    task automatic sleep_chk(input logic keep);
        @(posedge core_clk);
        sleep_state <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(retention_ram_power_en, keep)
        @(posedge core_clk);
        sleep_state <= 1'b0;
        mdl[`OFF_AMP_TARGET] = 0;
        rd_chk(`OFF_AMP_TARGET, 0);
    endtask : sleep_chk
    task automatic test_done();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    // main sequence
    initial begin
        void'($urandom(72216));
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        `CHK({retention_ram_power_en, irq, amp_drive_level}, 8'h80)
        wr(10'h055, 'hA5);
        foreach (rd_list[i]) begin
            t = rd_list[i];
            rd_chk(t, mdl_val(t));
        end
        for (int c = 0; c < 8; c++) begin
            wr(`OFF_TRANSITION_SPEED, c);
            repeat (2) @(posedge core_clk);
            #1;
            `CHK(fast_transition, c == 1)
            rd_chk(`OFF_TRANSITION_SPEED, c);
        end
        wr(`OFF_IRQ_ENABLE, 7);
        lock_chk(0, 1 + $urandom % 7, 1);
        lock_chk(0, 0, 1);
        lock_chk(0, 5, 0);
        lock_chk(1, 1 + $urandom % 7, 1);
        lock_chk(1, 4, 0);
        rd_chk(`OFF_IRQ_STATUS, 6);
        `CHK(irq, 1'b1)
        wr(`OFF_IRQ_CLEAR, 6);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(irq, 1'b0)
        t = 2 + $urandom % 62;
        wr(`OFF_AMP_TARGET, t);
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(amp_drive_level, t[5:0])
        rd_chk(`OFF_AMP_TARGET, t);
        wr(`OFF_MODE_CONTROL, 2);
        wr(`OFF_AMP_TARGET, t ^ 'h20);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(amp_drive_level == 6'(t ^ 'h20), 1'b0)
        repeat (150) @(posedge core_clk);
        #1;
        `CHK(amp_drive_level, 6'(t ^ 'h20))
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 5; c++) begin
                wake_chk(s, c, $urandom % 4);
            end
        end
        rd_chk(`OFF_IRQ_STATUS, 1);
        wr(`OFF_IRQ_ENABLE, 6);
        @(posedge core_clk);
        #1;
        `CHK(irq, 1'b0)
        sleep_chk(1'b1);
        wr(`OFF_WAKE_CFG_HIGH, 0);
        wr(`OFF_WAKE_CFG_LOW, 'h70);
        repeat (4) @(posedge core_clk);
        wait_sig(2, 300, n);
        `CHK(n, 300)
        sleep_chk(1'b0);
        test_done();
    end
endmodule : radio_timing_wake_config_test
`default_nettype wire
